// file: logic/thi_consts.svh
// Constants of the touch host I2C slave and interrupt block.
// Summary of operation
// - Enabled stage completion pulls interrupt line low.
// - Status read clears flags, releases line.
// - Offset 0x007 holds per-stage completion enables.
// - 0x00A completion flags clear unless still triggering.
// - Touch mode interrupts on contact and lift-off.
// - Touch enables at 0x005 low, 0x006 high.
// - Touch status at 0x008 low, 0x009 high.
// - Touch interrupt holds until status is read.
// - Any enabled threshold status change raises touch interrupt.
// - Fixed-address slave only, never starts transfers.
// - Acknowledge matching address; bit zero selects direction.
// - Stop returns idle and zeroes the pointer.
// - Two pointer bytes, upper first, ten bits used.
// - Data high byte then low byte form word.
// - Pointer advances per write, saturates, drops data.
// - Read returns high byte then low byte.
// - Pointer advances per read until master nacks.
// - At top address reads repeat last register.
`ifndef THI_CONSTS_SVH
`define THI_CONSTS_SVH

`define THI_REG_W       16
`define THI_PTR_W       10
`define THI_DEV_ADDR    7'h2E
`define THI_PTR_MAX     10'h3FF
`define THI_PTR_RST     10'h000
`define THI_OFF_EN_LO   10'h005
`define THI_OFF_EN_HI   10'h006
`define THI_OFF_EN_DONE 10'h007
`define THI_OFF_ST_LO   10'h008
`define THI_OFF_ST_HI   10'h009
`define THI_OFF_ST_DONE 10'h00A
`define THI_REG_RST     16'h0000
`define THI_BIT_LAST    4'h8
`define THI_TX_LAST     4'h7

`endif

// file: logic/thi_pkg.sv
// Types shared by the touch host I2C slave and interrupt block.
`include "thi_consts.svh"
package thi_pkg;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_AACK  = 7'h04,
        ST_WBYTE = 7'h08,
        ST_WACK  = 7'h10,
        ST_RBYTE = 7'h20,
        ST_RACK  = 7'h40
    } thi_state_t;

    typedef struct packed {
        logic [`THI_REG_W-1:0] done;
        logic [`THI_REG_W-1:0] act_lo;
        logic [`THI_REG_W-1:0] act_hi;
    } thi_evt_t;

    typedef struct packed {
        thi_state_t            state;
        logic [7:0]            sh;
        logic [3:0]            cnt;
        logic                  rw;
        logic                  nack;
        logic [1:0]            bidx;
        logic                  rphase;
        logic [`THI_PTR_W-1:0] ptr;
        logic [7:0]            dhi;
        logic [`THI_REG_W-1:0] word;
        logic [`THI_REG_W-1:0] en_lo;
        logic [`THI_REG_W-1:0] en_hi;
        logic [`THI_REG_W-1:0] en_done;
        logic [`THI_REG_W-1:0] done_st;
        logic                  scl_q;
        logic                  sda_q;
        logic                  oe_n;
        logic                  irq_oe_n;
    } thi_i2c_t;

endpackage

// file: logic/thi_sync3.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module thi_sync3 #(
    parameter int         W    = 2,
    parameter logic [W-1:0] INIT = '1
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } thi_sync_t;

    thi_sync_t r, n;

    // A bit only moves once the second and third stages agree.
    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.f[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= {INIT, INIT, INIT, INIT};
        end else begin
            r <= n;
        end
    end

    assign dout = r.f;
endmodule // thi_sync3

// file: logic/thi_touch_grp.sv
// One touch threshold group: live status and a sticky change flag.
`timescale 1ns/1ps
`include "thi_consts.svh"
module thi_touch_grp (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic [`THI_REG_W-1:0] act,
    input  wire logic [`THI_REG_W-1:0] en,
    input  wire logic                  clr,
    output logic      [`THI_REG_W-1:0] status,
    output logic                       pend
);
    typedef struct packed {
        logic [`THI_REG_W-1:0] cur;
        logic                  pend;
    } thi_grp_t;

    thi_grp_t r, n;
    logic [`THI_REG_W-1:0] masked;

    always_comb begin
        masked = act & en;
        n      = r;
        n.cur  = masked;
        // Contact and lift-off both change the masked bits.
        n.pend = (r.pend & ~clr) | (masked != r.cur);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign status = r.cur;
    assign pend   = r.pend;
endmodule // thi_touch_grp

// file: logic/thi_touch_host_i2c.sv
// I2C register slave and open-drain interrupt of the touch controller.
`timescale 1ns/1ps
`include "thi_consts.svh"
module thi_touch_host_i2c (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    input  wire thi_pkg::thi_evt_t evt,
    output logic                  sda_o,
    output logic                  sda_oe_n,
    output logic                  int_o,
    output logic                  int_oe_n
);
    import thi_pkg::*;

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    logic [1:0] pins_f;
    logic       scl_f;
    logic       sda_f;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;

    thi_sync3 #(
        .W    (2),
        .INIT (2'h3)
    ) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .din   ({scl_i, sda_i}),
        .dout  (pins_f)
    );

    thi_i2c_t r, n;

    assign scl_f    = pins_f[1];
    assign sda_f    = pins_f[0];
    assign scl_rise = scl_f & ~r.scl_q;
    assign scl_fall = ~scl_f & r.scl_q;
    assign start_c  = scl_f & r.scl_q & r.sda_q & ~sda_f;
    assign stop_c   = scl_f & r.scl_q & ~r.sda_q & sda_f;

    // ------------------------------------------------------------
    // Touch groups
    // ------------------------------------------------------------
    logic [`THI_REG_W-1:0] st_lo;
    logic [`THI_REG_W-1:0] st_hi;
    logic                  tp_lo;
    logic                  tp_hi;
    logic                  clr_lo;
    logic                  clr_hi;
    logic                  clr_done;

    thi_touch_grp u_grp_lo (
        .clock  (clock),
        .rstn   (rstn),
        .act    (evt.act_lo),
        .en     (r.en_lo),
        .clr    (clr_lo),
        .status (st_lo),
        .pend   (tp_lo)
    );

    thi_touch_grp u_grp_hi (
        .clock  (clock),
        .rstn   (rstn),
        .act    (evt.act_hi),
        .en     (r.en_hi),
        .clr    (clr_hi),
        .status (st_hi),
        .pend   (tp_hi)
    );

    // ------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------
    function automatic logic [`THI_REG_W-1:0] rd_mux(input logic [`THI_PTR_W-1:0] a);
        logic [`THI_REG_W-1:0] v;
        v = `THI_REG_RST;
        case (a)
            `THI_OFF_EN_LO:   v = r.en_lo;
            `THI_OFF_EN_HI:   v = r.en_hi;
            `THI_OFF_EN_DONE: v = r.en_done;
            `THI_OFF_ST_LO:   v = st_lo;
            `THI_OFF_ST_HI:   v = st_hi;
            `THI_OFF_ST_DONE: v = r.done_st;
            default:          v = `THI_REG_RST;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------
    logic                  ld;
    logic                  wr;
    logic [`THI_PTR_W-1:0] ld_addr;
    logic [`THI_PTR_W-1:0] ptr_inc;

    // Saturating increment: the pointer never wraps past the top.
    assign ptr_inc = (r.ptr == `THI_PTR_MAX) ? r.ptr : r.ptr + 10'h001;

    always_comb begin
        n        = r;
        ld       = 1'b0;
        wr       = 1'b0;
        ld_addr  = r.ptr;
        clr_lo   = 1'b0;
        clr_hi   = 1'b0;
        clr_done = 1'b0;
        n.scl_q  = scl_f;
        n.sda_q  = sda_f;
        case (r.state)
            ST_IDLE: begin
                n.state = ST_IDLE;
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    n.sh  = {r.sh[6:0], sda_f};
                    n.cnt = r.cnt + 4'h1;
                end
                if (scl_fall && r.cnt == `THI_BIT_LAST) begin
                    if (r.sh[7:1] == `THI_DEV_ADDR) begin
                        n.state = ST_AACK;
                        n.rw    = r.sh[0];
                    end else begin
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_AACK: begin
                if (scl_fall) begin
                    n.cnt = 4'h0;
                    if (r.rw) begin
                        // The word is captured here, so flags drop at once.
                        ld       = 1'b1;
                        n.rphase = 1'b0;
                        n.state  = ST_RBYTE;
                    end else begin
                        n.bidx  = 2'h0;
                        n.state = ST_WBYTE;
                    end
                end
            end
            ST_WBYTE: begin
                if (scl_rise) begin
                    n.sh  = {r.sh[6:0], sda_f};
                    n.cnt = r.cnt + 4'h1;
                end
                if (scl_fall && r.cnt == `THI_BIT_LAST) begin
                    n.state = ST_WACK;
                    case (r.bidx)
                        2'h0: begin
                            n.ptr[9:8] = r.sh[1:0];
                            n.bidx     = 2'h1;
                        end
                        2'h1: begin
                            n.ptr[7:0] = r.sh;
                            n.bidx     = 2'h2;
                        end
                        2'h2: begin
                            n.dhi  = r.sh;
                            n.bidx = 2'h3;
                        end
                        default: begin
                            wr     = (r.ptr != `THI_PTR_MAX);
                            n.ptr  = ptr_inc;
                            n.bidx = 2'h2;
                        end
                    endcase
                end
            end
            ST_WACK: begin
                if (scl_fall) begin
                    n.cnt   = 4'h0;
                    n.state = ST_WBYTE;
                end
            end
            ST_RBYTE: begin
                if (scl_fall) begin
                    // High byte leaves first, the low byte follows it up.
                    n.word = {r.word[14:0], 1'b0};
                    n.cnt  = r.cnt + 4'h1;
                    if (r.cnt == `THI_TX_LAST) begin
                        n.state = ST_RACK;
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    n.nack = sda_f;
                end
                if (scl_fall) begin
                    if (r.nack) begin
                        n.state = ST_IDLE;
                    end else begin
                        n.cnt   = 4'h0;
                        n.state = ST_RBYTE;
                        if (r.rphase) begin
                            n.ptr    = ptr_inc;
                            ld       = 1'b1;
                            ld_addr  = ptr_inc;
                            n.rphase = 1'b0;
                        end else begin
                            n.rphase = 1'b1;
                        end
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        if (ld) begin
            n.word   = rd_mux(ld_addr);
            clr_lo   = (ld_addr == `THI_OFF_ST_LO);
            clr_hi   = (ld_addr == `THI_OFF_ST_HI);
            clr_done = (ld_addr == `THI_OFF_ST_DONE);
        end

        if (wr) begin
            case (r.ptr)
                `THI_OFF_EN_LO:   n.en_lo   = {r.dhi, r.sh};
                `THI_OFF_EN_HI:   n.en_hi   = {r.dhi, r.sh};
                `THI_OFF_EN_DONE: n.en_done = {r.dhi, r.sh};
                default:          n.en_lo   = n.en_lo;
            endcase
        end

        // A completion in the clearing cycle survives the clear.
        n.done_st = (r.done_st & {`THI_REG_W{~clr_done}}) | (evt.done & r.en_done);

        if (start_c) begin
            n.state = ST_ADDR;
            n.cnt   = 4'h0;
        end
        if (stop_c) begin
            n.state = ST_IDLE;
            n.ptr   = `THI_PTR_RST;
        end

        n.oe_n = ~((n.state == ST_AACK) | (n.state == ST_WACK) |
                   ((n.state == ST_RBYTE) & ~n.word[15]));
        n.irq_oe_n = ~((|(n.done_st & n.en_done)) | tp_lo | tp_hi);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r          <= '0;
            r.state    <= ST_IDLE;
            r.ptr      <= `THI_PTR_RST;
            r.en_lo    <= `THI_REG_RST;
            r.en_hi    <= `THI_REG_RST;
            r.en_done  <= `THI_REG_RST;
            r.done_st  <= `THI_REG_RST;
            r.scl_q    <= 1'b1;
            r.sda_q    <= 1'b1;
            r.oe_n     <= 1'b1;
            r.irq_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Open-drain outputs
    // ------------------------------------------------------------
    // Both lines are open drain: they only ever pull low.
    assign sda_o    = 1'b0;
    assign sda_oe_n = r.oe_n;
    assign int_o    = 1'b0;
    assign int_oe_n = r.irq_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_done_irq_low: assert property (
        (|(evt.done & r.en_done)) |=> !int_oe_n)
        else $error("Enabled completion did not pull the line low.");

    a_done_masked: assert property (
        ##1 ((r.done_st & ~$past(r.done_st) & ~$past(evt.done & r.en_done)) == '0))
        else $error("Completion flag set without an enabled event.");

    a_done_clear: assert property (
        (clr_done && !(|(evt.done & r.en_done))) |=> (r.done_st == '0))
        else $error("Completion status not cleared by its read.");

    a_touch_hold: assert property (
        (tp_lo && !clr_lo) |=> (tp_lo && !int_oe_n))
        else $error("Touch interrupt dropped before status read.");

    a_addr_ack: assert property (
        (r.state == ST_ADDR && n.state == ST_AACK) |=> (!sda_oe_n && $past(r.sh[7:1]) == `THI_DEV_ADDR))
        else $error("Acknowledge given for a foreign address.");

    a_idle_quiet: assert property (
        (r.state == ST_IDLE) |-> sda_oe_n)
        else $error("Data line driven while idle.");

    a_stop_idle: assert property (
        stop_c |=> (r.state == ST_IDLE && r.ptr == `THI_PTR_RST))
        else $error("Stop did not return to idle with zero pointer.");

    a_write_pair: assert property (
        (wr && r.ptr == `THI_OFF_EN_DONE) |=> (r.en_done == $past({r.dhi, r.sh})))
        else $error("Write data bytes not combined high then low.");

    a_ptr_top: assert property (
        (r.ptr == `THI_PTR_MAX && r.state == ST_RACK && !stop_c) |=> (r.ptr == `THI_PTR_MAX))
        else $error("Pointer moved past the top address.");

    a_read_release: assert property (
        (clr_done && !(|(evt.done & r.en_done)) && !tp_lo && !tp_hi) |=> int_oe_n)
        else $error("Status read did not release the interrupt line.");

    // Touch path: the group flags the change, then the line follows one cycle later.
    a_touch_raise: assert property (
        ((evt.act_lo & r.en_lo) != st_lo) |-> ##2 !int_oe_n)
        else $error("Touch status change did not raise the interrupt.");

    a_touch_hi_hold: assert property (
        (tp_hi && !clr_hi) |=> (tp_hi && !int_oe_n))
        else $error("High group interrupt dropped before status read.");

    a_write_top_drop: assert property (
        (r.state == ST_WBYTE && scl_fall && r.cnt == `THI_BIT_LAST && r.bidx == 2'h3 && r.ptr == `THI_PTR_MAX)
        |=> (r.ptr == `THI_PTR_MAX && $stable(r.en_lo) && $stable(r.en_hi) && $stable(r.en_done)))
        else $error("Write at the top address was not discarded.");

    c_reg_write: cover property (wr && r.ptr == `THI_OFF_EN_DONE);
    c_status_read: cover property (clr_done);
    c_touch_irq: cover property (tp_hi ##1 clr_hi);
    c_seq_read: cover property (r.state == ST_RACK && r.rphase && n.state == ST_RBYTE);
    c_top_write: cover property (r.ptr == `THI_PTR_MAX && r.bidx == 2'h3 && scl_fall);
endmodule // thi_touch_host_i2c

// file: bench/thi_host_mdl.sv
// Behavioural I2C master standing in for the host microcontroller.
`timescale 1ns/1ps
`include "thi_consts.svh"
module thi_host_mdl (
    output logic      scl,
    output logic      sda_oe_n,
    input  wire logic sda
);
    // ------------------------------------------------------------
    // Bit level
    // ------------------------------------------------------------
    // SCL rests high between frames; SDA moves 6 ns after SCL falls so
    // the slave's filter never sees data move while the clock is high.
    // The low phase is 30 ns because the slave answers up to five cycles
    // after it sees SCL fall, and its answer must settle before SCL rises.
    initial begin
        scl      = 1'b1;
        sda_oe_n = 1'b1;
    end

    task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #6 sda_oe_n = tx[i];
            #24 scl = 1'b1;
            #18 rx[i] = sda;
            scl = 1'b0;
        end
    endtask

    task automatic start();
        #6 sda_oe_n = 1'b1;
        #24 scl = 1'b1;
        #18 sda_oe_n = 1'b0;
        #24 scl = 1'b0;
    endtask

    task automatic stop();
        #6 sda_oe_n = 1'b0;
        #24 scl = 1'b1;
        #18 sda_oe_n = 1'b1;
        #48;
    endtask

    task automatic byte_w(input logic [7:0] b, output logic ack);
        logic [8:0] rx;
        bits9({b, 1'b1}, rx);
        ack = ~rx[0];
    endtask

    task automatic byte_r(input logic last, output logic [7:0] d);
        logic [8:0] rx;
        bits9({8'hFF, last}, rx);
        d = rx[8:1];
    endtask

    // ------------------------------------------------------------
    // Register transactions
    // ------------------------------------------------------------
    task automatic set_ptr(input logic [9:0] p, input logic [5:0] junk, output logic ok);
        logic a;
        start();
        byte_w({`THI_DEV_ADDR, 1'b0}, a);
        ok = a;
        byte_w({junk, p[9:8]}, a);
        ok = ok & a;
        byte_w(p[7:0], a);
        ok = ok & a;
    endtask

    task automatic wr_regs(input logic [9:0] p, input logic [5:0] junk, input int n,
                           input logic [15:0] w [8], output logic ok);
        logic a;
        set_ptr(p, junk, ok);
        // Words go whole, so the byte count is always even.
        for (int k = 0; k < n; k++) begin
            byte_w(w[k][15:8], a);
            ok = ok & a;
            byte_w(w[k][7:0], a);
            ok = ok & a;
        end
        stop();
    endtask

    task automatic rd_regs(input logic [9:0] p, input logic set, input int n,
                           output logic [15:0] d [8], output logic ok);
        logic       a;
        logic [7:0] hi;
        logic [7:0] lo;
        ok = 1'b1;
        if (set) begin
            set_ptr(p, 6'h2A, ok);
        end
        start();
        byte_w({`THI_DEV_ADDR, 1'b1}, a);
        ok = ok & a;
        for (int k = 0; k < n; k++) begin
            byte_r(1'b0, hi);
            byte_r(k == n - 1, lo);
            d[k] = {hi, lo};
        end
        stop();
    endtask
endmodule // thi_host_mdl

// file: bench/thi_touch_host_i2c_and_irq_test.sv
// Self-checking bench of the touch host I2C slave and interrupt block.
`timescale 1ns/1ps
`include "thi_consts.svh"
module thi_touch_host_i2c_and_irq_test;
    import thi_pkg::*;

    logic              clock;
    logic              rstn;
    thi_evt_t          evt;
    logic              scl;
    logic              m_oe_n;
    wire               sda;
    logic              sda_o;
    logic              sda_oe_n;
    logic              int_o;
    logic              int_oe_n;
    int                num_errors;
    int                total_checks;
    logic [15:0]       lfsr_r;
    logic [15:0]       wbuf [8];
    logic [15:0]       rbuf [8];
    logic [15:0]       r;
    logic              ok;
    logic              a;
    logic [1:0]        acts [3];
    logic [6:0]        bad [3];

    // Pull-up on SDA: high unless a party pulls it low.
    assign sda = m_oe_n & sda_oe_n;

    thi_touch_host_i2c i_dut (
        .clock    (clock),
        .rstn     (rstn),
        .scl_i    (scl),
        .sda_i    (sda),
        .evt      (evt),
        .sda_o    (sda_o),
        .sda_oe_n (sda_oe_n),
        .int_o    (int_o),
        .int_oe_n (int_oe_n)
    );

    thi_host_mdl i_host (
        .scl      (scl),
        .sda_oe_n (m_oe_n),
        .sda      (sda)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic rnd(output logic [15:0] v);
        lfsr_r = lfsr_next(lfsr_r);
        v = lfsr_r;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Bounded wait for the interrupt line level; a timeout ends the run.
    task automatic wait_int(input logic lvl);
        int n;
        n = 0;
        while (int_oe_n !== lvl && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({15'h0000, int_oe_n}, {15'h0000, lvl});
        if (int_oe_n !== lvl) begin
            end_sim();
        end
    endtask

    task automatic pulse_done(input logic [15:0] v);
        @(posedge clock);
        #1 evt.done = v;
        @(posedge clock);
        #1 evt.done = 16'h0000;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        evt = '0;
        lfsr_r = 16'h8ACB;
        num_errors = 0;
        total_checks = 0;
        acts = '{2'h1, 2'h3, 2'h0};
        bad = '{7'h2F, 7'h2C, 7'h6E};
        repeat (5) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        check({15'h0000, int_oe_n}, 16'h0001);
        i_host.rd_regs(`THI_OFF_EN_LO, 1'b1, 6, rbuf, ok);
        check({15'h0000, ok}, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            check(rbuf[k], `THI_REG_RST);
        end
        rnd(wbuf[0]);
        rnd(wbuf[1]);
        wbuf[2] = 16'h8000;
        rnd(r);
        i_host.wr_regs(`THI_OFF_EN_LO, r[7:2], 3, wbuf, ok);
        check({15'h0000, ok}, 16'h0001);
        // No pointer load: the stop must have put the pointer at zero.
        i_host.rd_regs(10'h000, 1'b0, 8, rbuf, ok);
        for (int k = 0; k < 8; k++) begin
            check(rbuf[k], k >= 5 ? wbuf[k - 5] : 16'h0000);
        end
        // Eight words at the top address: a wrapping pointer would reach the enables.
        for (int k = 0; k < 8; k++) begin
            rnd(rbuf[k]);
        end
        i_host.wr_regs(`THI_PTR_MAX, 6'h15, 8, rbuf, ok);
        check({15'h0000, ok}, 16'h0001);
        i_host.rd_regs(`THI_PTR_MAX - 10'h001, 1'b1, 3, rbuf, ok);
        for (int k = 0; k < 3; k++) begin
            check(rbuf[k], `THI_REG_RST);
        end
        i_host.rd_regs(`THI_OFF_EN_LO, 1'b1, 3, rbuf, ok);
        for (int k = 0; k < 3; k++) begin
            check(rbuf[k], wbuf[k]);
        end
        i_host.rd_regs(`THI_OFF_ST_LO, 1'b1, 2, rbuf, ok);
        wait_int(1'b1);
        foreach (bad[i]) begin
            i_host.start();
            i_host.byte_w({bad[i], 1'b0}, a);
            check({15'h0000, a}, 16'h0000);
            i_host.stop();
        end
        pulse_done(16'h0001);
        repeat (20) @(posedge clock);
        #1;
        check({15'h0000, int_oe_n}, 16'h0001);
        pulse_done(16'h8001);
        wait_int(1'b0);
        i_host.rd_regs(`THI_OFF_ST_DONE, 1'b1, 1, rbuf, ok);
        check(rbuf[0], 16'h8000);
        wait_int(1'b1);
        i_host.rd_regs(`THI_OFF_ST_DONE, 1'b1, 1, rbuf, ok);
        check(rbuf[0], 16'h0000);
        for (int g = 0; g < 2; g++) begin
            wbuf[0] = 16'h0003;
            rnd(r);
            i_host.wr_regs(`THI_OFF_EN_LO + 10'(g), r[5:0], 1, wbuf, ok);
            i_host.rd_regs(`THI_OFF_ST_LO + 10'(g), 1'b1, 1, rbuf, ok);
            wait_int(1'b1);
            for (int k = 0; k < 3; k++) begin
                // Bits outside the enable move at random and must stay silent.
                rnd(r);
                @(posedge clock);
                #1;
                if (g == 0) begin
                    evt.act_lo = {r[15:2], acts[k]};
                end else begin
                    evt.act_hi = {r[15:2], acts[k]};
                end
                wait_int(1'b0);
                if (k == 0) begin
                    repeat (200) @(posedge clock);
                    #1;
                    check({15'h0000, int_oe_n}, 16'h0000);
                end
                i_host.rd_regs(`THI_OFF_ST_LO + 10'(g), 1'b1, 1, rbuf, ok);
                check(rbuf[0], {14'h0000, acts[k]});
                wait_int(1'b1);
            end
        end
        end_sim();
    end
endmodule // thi_touch_host_i2c_and_irq_test
